//--- rtl/pcwin_regs.sv
// window enable and i/o window control registers with claim gating
//
// Design decision made here: the plain strobed port.
`timescale 1ns/1ps
module pcwin_regs (
	input  wire logic        clk_in,
	input  wire logic        rst_n_in,
	input  wire logic [11:0] addr_in,
	input  wire logic [7:0]  wdata_in,
	input  wire logic        wr_in,
	input  wire logic        rd_in,
	output logic [7:0]       rdata_out,
	input  wire logic [1:0]  io_win_hit_in,
	input  wire logic [4:0]  mem_win_hit_in,
	input  wire logic        io_cycle_in,
	input  wire logic        mem_cycle_in,
	input  wire logic        card_iois16_in,
	output logic             claim_out,
	output logic             io_width16_out,
	output logic [3:0]       io_cycles_out,
	output logic [1:0]       io_win_enable_out,
	output logic [4:0]       mem_win_enable_out
);
	// ***************************************************************
	// registers
	// ***************************************************************
	logic [7:0] window_enable;
	logic [7:0] io_window_control;
	logic       card_16bit;
	logic [1:0] io_hit_en;
	logic [4:0] mem_hit_en;
	pcwin_pkg::pcwin_io_timing_s timing1;
	pcwin_pkg::pcwin_io_timing_s timing0;
	pcwin_pkg::pcwin_io_ctrl_s   ctrl1;
	pcwin_pkg::pcwin_io_ctrl_s   ctrl0;

	// enable register; reserved bit 5 never stored
	always_ff @(posedge clk_in) begin
		if (!rst_n_in) begin
			window_enable <= pcwin_pkg::WINDOW_ENABLE_RESET; // [RL2]
		end else if (wr_in && addr_in == pcwin_pkg::WINDOW_ENABLE_ADDR) begin
			window_enable <= wdata_in & pcwin_pkg::WINDOW_ENABLE_MASK; // [RL5]
		end
	end

	// i/o control register, all bits read/write
	always_ff @(posedge clk_in) begin
		if (!rst_n_in) begin
			io_window_control <= pcwin_pkg::IO_WINDOW_CONTROL_RESET; // [RL14]
		end else if (wr_in &&
			addr_in == pcwin_pkg::IO_WINDOW_CONTROL_ADDR) begin
			io_window_control <= wdata_in;
		end
	end

	// read data one cycle after the strobe; unmapped reads zero
	always_ff @(posedge clk_in) begin
		if (!rst_n_in) begin
			rdata_out <= 8'h00;
		end else if (rd_in) begin
			case (addr_in)
				pcwin_pkg::WINDOW_ENABLE_ADDR:     rdata_out <= window_enable;
				pcwin_pkg::IO_WINDOW_CONTROL_ADDR: rdata_out <= io_window_control;
				default:                           rdata_out <= 8'h00;
			endcase
		end else begin
			rdata_out <= 8'h00;
		end
	end

	// ***************************************************************
	// window gating
	// ***************************************************************
	assign io_win_enable_out = {window_enable[pcwin_pkg::IO_WIN1_ENABLE_BIT],
		window_enable[pcwin_pkg::IO_WIN0_ENABLE_BIT]}; // [RL3]
	assign mem_win_enable_out = window_enable[pcwin_pkg::MEM_WIN_ENABLE_LSB
		+: pcwin_pkg::NUM_MEM_WIN]; // [RL4]
	assign io_hit_en  = io_win_hit_in & io_win_enable_out;
	assign mem_hit_en = mem_win_hit_in & mem_win_enable_out;
	// decode hits only count through enabled windows
	assign claim_out = (io_cycle_in && |io_hit_en) ||
		(mem_cycle_in && |mem_hit_en); // [RL1]

	// card pin is asynchronous, so synchronise first
	pcwin_sync u_sync (
		.clk_in   (clk_in),
		.rst_n_in (rst_n_in),
		.d_in     (card_iois16_in),
		.q_out    (card_16bit)
	);

	// one nibble per window, window 1 in the upper half
	assign ctrl1 = io_window_control[pcwin_pkg::IO_CTRL_WIN1_LSB +: 4];
	assign ctrl0 = io_window_control[pcwin_pkg::IO_CTRL_WIN0_LSB +: 4];

	pcwin_io_sizer u_size1 (
		.ctrl_in       (ctrl1),
		.card_16bit_in (card_16bit),
		.timing_out    (timing1)
	);
	pcwin_io_sizer u_size0 (
		.ctrl_in       (ctrl0),
		.card_16bit_in (card_16bit),
		.timing_out    (timing0)
	);

	// window 0 wins if both ranges overlap, a fixed priority
	always_ff @(posedge clk_in) begin
		if (!rst_n_in) begin
			io_width16_out <= 1'b0;
			io_cycles_out  <= 4'h0;
		end else if (io_cycle_in && io_hit_en[0]) begin
			io_width16_out <= timing0.width16; // [RL15]
			io_cycles_out  <= timing0.cycles;
		end else if (io_cycle_in && io_hit_en[1]) begin
			io_width16_out <= timing1.width16; // [RL15]
			io_cycles_out  <= timing1.cycles;
		end else begin
			io_width16_out <= 1'b0;
			io_cycles_out  <= 4'h0;
		end
	end
endmodule : pcwin_regs

//--- pkg/pcwin_pkg.sv
// constants and types shared by the window enable and i/o control block
// How it works
// RL1: disabled window never claims host cycles
// RL2: window enable register resets to 00h
// RL3: bit7 enables io window1, bit6 window0
// RL4: bits 4..0 enable memory windows 4..0
// RL5: bit 5 reserved, reads zero, ignores writes
// RL6: bit7 adds wait to window1 16-bit
// RL7: bit3 adds wait to window0 16-bit
// RL8: bit6 shortens window1 8-bit cycles
// RL9: bit2 shortens window0 8-bit cycles
// RL10: bit5 takes window1 width from card
// RL11: bit1 takes window0 width from card
// RL12: bit4 fixed width for window1
// RL13: bit0 fixed width for window0
// RL14: i/o control register resets to 00h
// RL15: decoding window's settings govern each access
package pcwin_pkg;
	// ***************************************************************
	// register map
	// ***************************************************************
	localparam logic [11:0] WINDOW_ENABLE_ADDR     = 12'h806;
	localparam logic [11:0] IO_WINDOW_CONTROL_ADDR = 12'h807;
	localparam logic [7:0]  WINDOW_ENABLE_RESET    = 8'h00;
	localparam logic [7:0]  IO_WINDOW_CONTROL_RESET = 8'h00;
	localparam logic [7:0]  WINDOW_ENABLE_MASK     = 8'hdf;
	// ***************************************************************
	// field positions
	// ***************************************************************
	localparam int IO_WIN1_ENABLE_BIT = 7;
	localparam int IO_WIN0_ENABLE_BIT = 6;
	localparam int MEM_WIN_ENABLE_LSB = 0;
	localparam int IO_CTRL_WIN1_LSB   = 4;
	localparam int IO_CTRL_WIN0_LSB   = 0;
	localparam int NUM_MEM_WIN        = 5;
	// ***************************************************************
	// cycle timing in clock periods
	// ***************************************************************
	localparam logic [3:0] STD_8BIT_CYCLES   = 4'h6;
	localparam logic [3:0] SHORT_8BIT_CYCLES = 4'h3;
	localparam logic [3:0] STD_16BIT_CYCLES  = 4'h3;
	localparam logic [3:0] WAIT_STATE_CYCLES = 4'h1;
	// per-window nibble of the i/o control register
	typedef struct packed {
		logic extend_16bit;
		logic shorten_8bit;
		logic auto_size;
		logic width_sel;
	} pcwin_io_ctrl_s;
	// host i/o access as seen by the sizer
	typedef struct packed {
		logic       width16;
		logic [3:0] cycles;
	} pcwin_io_timing_s;
endpackage : pcwin_pkg

//--- rtl/pcwin_io_sizer.sv
// width and cycle length for one i/o window
`timescale 1ns/1ps
module pcwin_io_sizer (
	input  wire pcwin_pkg::pcwin_io_ctrl_s   ctrl_in,
	input  wire logic                        card_16bit_in,
	output pcwin_pkg::pcwin_io_timing_s      timing_out
);
	// auto sizing overrides the fixed width bit
	always_comb begin
		timing_out.width16 = ctrl_in.auto_size ? card_16bit_in
			: ctrl_in.width_sel; // [RL10] [RL11] [RL12] [RL13]
		if (timing_out.width16) begin
			timing_out.cycles = ctrl_in.extend_16bit
				? pcwin_pkg::STD_16BIT_CYCLES + pcwin_pkg::WAIT_STATE_CYCLES
				: pcwin_pkg::STD_16BIT_CYCLES; // [RL6] [RL7]
		end else begin
			timing_out.cycles = ctrl_in.shorten_8bit
				? pcwin_pkg::SHORT_8BIT_CYCLES
				: pcwin_pkg::STD_8BIT_CYCLES; // [RL8] [RL9]
		end
	end
endmodule : pcwin_io_sizer

//--- rtl/pcwin_sync.sv
// two-flop synchroniser for a card pin
`timescale 1ns/1ps
module pcwin_sync (
	input  wire logic clk_in,
	input  wire logic rst_n_in,
	input  wire logic d_in,
	output logic      q_out
);
	logic stage1;
	// first flop feeds only the second
	always_ff @(posedge clk_in) begin
		if (!rst_n_in) begin
			stage1 <= 1'b0;
			q_out  <= 1'b0;
		end else begin
			stage1 <= d_in;
			q_out  <= stage1;
		end
	end
endmodule : pcwin_sync

//--- verif/pcwin_card_model.sv
// card model driving the 16-bit i/o indication pin
`timescale 1ns/1ps
module pcwin_card_model (
	input  wire logic clk_in,
	input  wire logic io16_req_in,
	output logic      iois16_out
);
	// pin moves just after an edge, as a card answering a decode
	always_ff @(posedge clk_in) begin
		iois16_out <= io16_req_in;
	end
endmodule : pcwin_card_model

//--- verif/pcwin_regs_asserts.sv
// port checks for the window enable and i/o control registers
`timescale 1ns/1ps
module pcwin_regs_checker (
	input wire logic clk_in, rst_n_in, wr_in, rd_in, io_cycle_in,
	input wire logic mem_cycle_in, claim_out, io_width16_out,
	input wire logic [11:0] addr_in,
	input wire logic [7:0] wdata_in, rdata_out,
	input wire logic [1:0] io_win_hit_in, io_win_enable_out,
	input wire logic [4:0] mem_win_hit_in, mem_win_enable_out,
	input wire logic [3:0] io_cycles_out
);
	default clocking @(posedge clk_in); endclocking
	default disable iff (!rst_n_in);
	// claim needs a hit on an enabled window of the cycle's kind
	a_claim_gate: assert property (
		claim_out == (io_cycle_in && |(io_win_hit_in & io_win_enable_out)
		|| mem_cycle_in && |(mem_win_hit_in & mem_win_enable_out)))
		else $error("claim wrong");
	a_reset_clear: assert property (disable iff (1'b0)
		!rst_n_in |=> io_win_enable_out == 2'h0 && mem_win_enable_out == 5'h00)
		else $error("enables not cleared");
	a_io_enable: assert property (
		wr_in && addr_in == 12'h806 |=> io_win_enable_out == $past(wdata_in[7:6]))
		else $error("io enable wrong");
	a_mem_enable: assert property (
		wr_in && addr_in == 12'h806 |=> mem_win_enable_out == $past(wdata_in[4:0]))
		else $error("mem enable wrong");
	a_rsvd_read: assert property (
		rd_in && addr_in == 12'h806 |=>
		rdata_out == {io_win_enable_out, 1'h0, mem_win_enable_out})
		else $error("enable readback wrong");
	a_rdata_idle: assert property (!rd_in |=> rdata_out == 8'h00)
		else $error("read data not idle");
	a_timing_idle: assert property (
		!(io_cycle_in && |io_win_hit_in) |=> io_cycles_out == 4'h0)
		else $error("timing not idle");
	a_timing_range: assert property (
		io_cycle_in && |(io_win_hit_in & io_win_enable_out) |=>
		(io_width16_out ? io_cycles_out inside
		{4'h3, 4'h4} : io_cycles_out inside {4'h3, 4'h6}))
		else $error("cycle length out of range");
	c_claim: cover property (claim_out && io_cycle_in);
	c_wide: cover property (io_width16_out);
	c_short: cover property (io_cycles_out == 4'h3 && !io_width16_out);
endmodule : pcwin_regs_checker
bind pcwin_regs pcwin_regs_checker i_chk (.clk_in, .rst_n_in, .wr_in, .rd_in,
	.io_cycle_in, .mem_cycle_in, .claim_out, .io_width16_out, .addr_in,
	.wdata_in, .rdata_out, .io_win_hit_in, .io_win_enable_out,
	.mem_win_hit_in, .mem_win_enable_out, .io_cycles_out);

//--- verif/pcwin_regs_tb_top.sv
// self-checking bench for the window enable and i/o control registers
`timescale 1ns/1ps
module pcwin_regs_tb_top;
	logic clk_in, rst_n_in, wr_in, rd_in, io_cycle_in, mem_cycle_in, io16_req;
	logic card_iois16_in, claim_out, io_width16_out;
	logic [11:0] addr_in;
	logic [7:0]  wdata_in, rdata_out;
	logic [1:0]  io_win_hit_in, io_win_enable_out;
	logic [4:0]  mem_win_hit_in, mem_win_enable_out;
	logic [3:0]  io_cycles_out;
	logic [7:0]  en_all;
	// enable outputs laid out as the register, bit 5 always zero
	assign en_all = {io_win_enable_out, 1'h0, mem_win_enable_out};
	int fails, num_checks;
	// nibble, card 16-bit, expected width, expected cycles
	logic [15:0] tbl [12] = '{16'h0006, 16'h4003, 16'h8006, 16'h9014,
		16'hd014, 16'h1013, 16'h2006, 16'h3006, 16'h2113, 16'h3113,
		16'ha114, 16'h6113};
	pcwin_regs i_pcwin_regs (.clk_in, .rst_n_in, .addr_in, .wdata_in, .wr_in,
		.rd_in, .rdata_out, .io_win_hit_in, .mem_win_hit_in, .io_cycle_in,
		.mem_cycle_in, .card_iois16_in, .claim_out, .io_width16_out,
		.io_cycles_out, .io_win_enable_out, .mem_win_enable_out);
	pcwin_card_model i_pcwin_card_model (.clk_in, .io16_req_in(io16_req),
		.iois16_out(card_iois16_in));
	task automatic chk(string n, logic [7:0] e, logic [7:0] g);
		num_checks++;
		if (g !== e) begin
			fails++;
			$display("MISMATCH %s exp %h got %h", n, e, g);
		end
	endtask : chk
	task automatic wr(logic [11:0] a, logic [7:0] d);
		addr_in <= a;
		wdata_in <= d;
		wr_in <= 1'h1;
		@(posedge clk_in) wr_in <= 1'h0;
		@(posedge clk_in);
	endtask : wr
	task automatic rd(logic [11:0] a, logic [7:0] e);
		addr_in <= a;
		rd_in <= 1'h1;
		@(posedge clk_in) rd_in <= 1'h0;
		#1 chk("rdata", e, rdata_out);
		@(posedge clk_in);
	endtask : rd
	// e: bit 7 claim, bit 4 width16, low nibble cycles (io only)
	task automatic hit(logic m, logic [4:0] h, logic [7:0] e);
		io_cycle_in <= !m;
		mem_cycle_in <= m;
		if (m) mem_win_hit_in <= h;
		else io_win_hit_in <= h[1:0];
		#1 chk("claim", {e[7], 7'h0}, {claim_out, 7'h0});
		@(posedge clk_in) {io_cycle_in, mem_cycle_in} <= 2'h0;
		{io_win_hit_in, mem_win_hit_in} <= 7'h00;
		#1 if (!m) chk("timing", e, {e[7:5], io_width16_out, io_cycles_out});
		@(posedge clk_in);
	endtask : hit
	task automatic stop_test();
		$display("checks %0d fails %0d", num_checks, fails);
		if (fails == 0 && num_checks > 0) $display("Testbench passed");
		else $display("Testbench failed");
		$finish;
	endtask : stop_test
	// 50 MHz clock
	initial begin
		clk_in = 1'h0;
		forever #10 clk_in = !clk_in;
	end
	// hang guard, far beyond the expected run
	initial begin
		#40000 fails++;
		stop_test();
	end
	// main sequence
	initial begin
		{rst_n_in, wr_in, rd_in, io_cycle_in, mem_cycle_in, io16_req} = 6'h00;
		{addr_in, wdata_in, io_win_hit_in, mem_win_hit_in} = 27'h0;
		repeat (3) @(posedge clk_in);
		rst_n_in <= 1'h1;
		rd(12'h806, 8'h00);
		chk("enables", 8'h00, en_all);
		rd(12'h807, 8'h00);
		hit(1'h0, 5'h03, 8'h00);
		wr(12'h806, 8'hff);
		rd(12'h806, 8'hdf);
		chk("enables", 8'hdf, en_all);
		wr(12'h806, 8'h55);
		hit(1'h0, 5'h02, 8'h00);
		hit(1'h0, 5'h01, 8'h86);
		hit(1'h1, 5'h02, 8'h00);
		hit(1'h1, 5'h10, 8'h80);
		wr(12'h806, 8'hc0);
		wr(12'h807, 8'hf0);
		hit(1'h0, 5'h01, 8'h86);
		hit(1'h0, 5'h03, 8'h86);
		for (int i = 0; i < 24; i++) begin
			io16_req <= tbl[i/2][8];
			wr(12'h807, {4'h0, tbl[i/2][15:12]} << (4 * (i % 2)));
			repeat (2) @(posedge clk_in);
			hit(1'h0, 5'(1 << (i % 2)), {3'h4, tbl[i/2][4:0]});
		end
		wr(12'h800, 8'hff);
		rd(12'h800, 8'h00);
		rd(12'h806, 8'hc0);
		// reset again with both registers non-zero
		rst_n_in <= 1'h0;
		repeat (2) @(posedge clk_in);
		rst_n_in <= 1'h1;
		rd(12'h806, 8'h00);
		rd(12'h807, 8'h00);
		chk("enables", 8'h00, en_all);
		stop_test();
	end
endmodule : pcwin_regs_tb_top
